// File: hw/gyro_cfg_map.vh
// register map, field layout and timing constants of the gyro config block
// assumes a 20 MHz core clock and a 32-bit AXI4-Lite register port
//
// Summary of operation
// - both config registers reset to zero, host reads and writes them
// - sync placement 0 disables; 1..7 tag temp, gyro x/y/z, accel x/y/z bit 0
// - sync pin latched; toggles once then holds until sample strobe captures
// - lowpass selector used only when both bypass bits are zero
// - filter choice is the bitwise inverse of the bypass bits
// - bypass bit0 or bypass 10 gives 32 kHz; sel 0/7 8 kHz; 1..6 1 kHz
// - bypass bits are gyro config bits 1:0; bit 2 is reserved
// - range field bits 4:3: 250, 500, 1000, 2000 degrees per second
// - output rate is 1 kHz over one plus divider, only on filtered 1 kHz
`ifndef GYRO_CFG_MAP_VH
`define GYRO_CFG_MAP_VH

// register indices and byte addresses (byte address is four times index)
`define GENERAL_CONFIG_IDX 8'h1a
`define GYRO_CONFIG_IDX 8'h1b
`define RATE_DIVIDER_IDX 8'h19
`define STATUS_IDX 8'h20
`define ADDR_W 8
`define GENERAL_CONFIG_ADDR 8'h68
`define GYRO_CONFIG_ADDR 8'h6c
`define RATE_DIVIDER_ADDR 8'h64
`define STATUS_ADDR 8'h80

// reset values and writable-bit masks
`define CFG_RESET 8'h00
`define GENERAL_CONFIG_MASK 8'h7f
`define GYRO_CONFIG_MASK 8'hfb

// general config fields
`define OVERFLOW_POLICY_BIT 6
`define SYNC_SEL_HI 5
`define SYNC_SEL_LO 3
`define LOWPASS_SEL_HI 2
`define LOWPASS_SEL_LO 0

// gyro config fields
`define SELFTEST_HI 7
`define SELFTEST_LO 5
`define RANGE_SEL_HI 4
`define RANGE_SEL_LO 3
`define BYPASS_HI 1
`define BYPASS_LO 0

// lowpass selector values that run the 8 kHz path, then the sync-off code and the filter-on choice
`define LOWPASS_SEL_WIDE 3'h0
`define LOWPASS_SEL_WIDE2 3'h7
`define SYNC_SEL_OFF 3'h0
`define FILTER_CHOICE_ON 2'h3

// path rate codes
`define PATH_1K 2'h0
`define PATH_8K 2'h1
`define PATH_32K 2'h2

// timing: rates in Hz, periods in core cycles derived from them
`define CLK_HZ 20000000
`define RATE_32K_HZ 32000
`define RATE_8K_HZ 8000
`define RATE_1K_HZ 1000
`define CYC_32K (`CLK_HZ / `RATE_32K_HZ)
`define CYC_8K (`CLK_HZ / `RATE_8K_HZ)
`define CNT_W 15

// bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hw/frame_sync_latch.v
// frame-sync pin latch: holds a toggle until the sample strobe takes it
// assumes the pin is already synchronous to clock_i

module frame_sync_latch (
    input wire clock_i,
    input wire rst_n_i,
    input wire frame_sync_pin_i,
    input wire sample_strobe_i,
    output reg latched_o,
    output reg captured_o
);

reg hold;

// latch and hold
// a toggle seen in the strobe cycle still lands: capture takes the old
// value and the new toggle re-arms the hold, so that toggle is not lost
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        latched_o <= 1'b0;
        hold <= 1'b0;
        captured_o <= 1'b0;
    end else begin
        if (sample_strobe_i) begin
            captured_o <= latched_o;
        end
        if (frame_sync_pin_i != latched_o && (!hold || sample_strobe_i)) begin
            latched_o <= frame_sync_pin_i;
            hold <= 1'b1;
        end else if (sample_strobe_i) begin
            hold <= 1'b0;
        end
    end
end

endmodule

// File: hw/gyro_filter_sync_config.v
// gyro filter, range and frame-sync configuration with AXI4-Lite registers
// assumes a single 20 MHz clock; the sample queue and sensor path are
// outside and take the policy, range and tag outputs from here
//
// The AXI4-Lite slave port was left to the implementer.
`include "gyro_cfg_map.vh"

module gyro_filter_sync_config #(
    parameter INT_1K_CYCLES = `CLK_HZ / `RATE_1K_HZ
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire frame_sync_pin_i,
    output wire queue_discard_on_full_o,
    output wire [1:0] rate_range_sel_o,
    output wire [2:0] rate_selftest_o,
    output wire [1:0] path_rate_o,
    output wire lowpass_active_o,
    output wire [2:0] lowpass_selector_o,
    output reg sample_strobe_o,
    output reg [6:0] sync_dest_o,
    output reg sync_bit_o
);

////////////////////////////////////////////////////////////////////////////
// helpers

// path rate from bypass bits and lowpass selector
function [1:0] path_of;
    input [1:0] bypass;
    input [2:0] sel;
    reg [1:0] choice;
    begin
        choice = ~bypass;
        if (choice != `FILTER_CHOICE_ON) begin
            path_of = `PATH_32K;
        end else if (sel == `LOWPASS_SEL_WIDE || sel == `LOWPASS_SEL_WIDE2) begin
            path_of = `PATH_8K;
        end else begin
            path_of = `PATH_1K;
        end
    end
endfunction

// merge one written byte lane into a register under its writable mask
function [7:0] merge_byte;
    input [7:0] old;
    input [7:0] data;
    input [7:0] mask;
    input en;
    begin
        if (en) begin
            merge_byte = data & mask;
        end else begin
            merge_byte = old;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] general_config;
reg [7:0] gyro_config;
reg [7:0] rate_divider;

reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;

wire [1:0] path_rate;
wire sync_latched;
wire sync_captured;
wire [2:0] sync_sel;

assign sync_sel = general_config[`SYNC_SEL_HI:`SYNC_SEL_LO];
assign path_rate = path_of(gyro_config[`BYPASS_HI:`BYPASS_LO],
    general_config[`LOWPASS_SEL_HI:`LOWPASS_SEL_LO]);

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel

// each address and data beat is parked until its partner arrives
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;

wire aw_fire = s_axi_awvalid && s_axi_awready;
wire w_fire = s_axi_wvalid && s_axi_wready;
wire have_aw = aw_held || aw_fire;
wire have_w = w_held || w_fire;
wire do_write = have_aw && have_w;
wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;

// write address/data staging and response
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        aw_addr <= 8'h00;
        aw_held <= 1'b0;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
    end else begin
        if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wr_addr)
            `GENERAL_CONFIG_ADDR, `GYRO_CONFIG_ADDR, `RATE_DIVIDER_ADDR,
            `STATUS_ADDR: begin
                s_axi_bresp <= `RESP_OKAY;
            end
            default: begin
                s_axi_bresp <= `RESP_SLVERR;
            end
            endcase
        end else begin
            if (aw_fire) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (w_fire) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
end

// config storage
// reserved bits are masked off so they always read back as zero
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        general_config <= `CFG_RESET;
        gyro_config <= `CFG_RESET;
        rate_divider <= `CFG_RESET;
    end else if (do_write) begin
        if (wr_addr == `GENERAL_CONFIG_ADDR) begin
            general_config <= merge_byte(general_config, wr_data[7:0],
                `GENERAL_CONFIG_MASK, wr_strb[0]);
        end
        if (wr_addr == `GYRO_CONFIG_ADDR) begin
            gyro_config <= merge_byte(gyro_config, wr_data[7:0],
                `GYRO_CONFIG_MASK, wr_strb[0]);
        end
        if (wr_addr == `RATE_DIVIDER_ADDR) begin
            rate_divider <= merge_byte(rate_divider, wr_data[7:0],
                8'hff, wr_strb[0]);
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel

assign s_axi_arready = !s_axi_rvalid;

// read data is registered one cycle after the address is taken
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
        `GENERAL_CONFIG_ADDR: begin
            s_axi_rdata <= {24'h000000, general_config};
        end
        `GYRO_CONFIG_ADDR: begin
            s_axi_rdata <= {24'h000000, gyro_config};
        end
        `RATE_DIVIDER_ADDR: begin
            s_axi_rdata <= {24'h000000, rate_divider};
        end
        `STATUS_ADDR: begin
            s_axi_rdata <= {24'h000000, 2'h0, sync_captured, sync_latched,
                lowpass_active_o, 1'b0, path_rate};
        end
        default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
        end
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// configuration outputs

assign queue_discard_on_full_o = general_config[`OVERFLOW_POLICY_BIT];
assign rate_range_sel_o = gyro_config[`RANGE_SEL_HI:`RANGE_SEL_LO];
assign rate_selftest_o = gyro_config[`SELFTEST_HI:`SELFTEST_LO];
assign path_rate_o = path_rate;
assign lowpass_active_o = (~gyro_config[`BYPASS_HI:`BYPASS_LO])
    == `FILTER_CHOICE_ON;
assign lowpass_selector_o = lowpass_active_o ?
    general_config[`LOWPASS_SEL_HI:`LOWPASS_SEL_LO] : `LOWPASS_SEL_WIDE;

////////////////////////////////////////////////////////////////////////////
// internal rate and output sample strobe

// periods kept as integers, cut to the counter width where they are used
localparam integer PERIOD_32K = `CYC_32K;
localparam integer PERIOD_8K = `CYC_8K;

reg [`CNT_W-1:0] rate_cnt;
reg [7:0] div_cnt;
reg [`CNT_W-1:0] period;
wire internal_tick = (rate_cnt >= period - 1'b1);

// period in core cycles for the selected path
always @* begin
    case (path_rate)
    `PATH_32K: begin
        period = PERIOD_32K[`CNT_W-1:0];
    end
    `PATH_8K: begin
        period = PERIOD_8K[`CNT_W-1:0];
    end
    default: begin
        period = INT_1K_CYCLES[`CNT_W-1:0];
    end
    endcase
end

// a path change mid-period just finishes against the new length;
// the first period after a change may be short, never long
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rate_cnt <= {`CNT_W{1'b0}};
    end else if (internal_tick) begin
        rate_cnt <= {`CNT_W{1'b0}};
    end else begin
        rate_cnt <= rate_cnt + 1'b1;
    end
end

// output divider
// the divider only acts on the filtered 1 kHz path
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        div_cnt <= 8'h00;
        sample_strobe_o <= 1'b0;
    end else if (path_rate != `PATH_1K) begin
        div_cnt <= 8'h00;
        sample_strobe_o <= internal_tick;
    end else if (internal_tick) begin
        if (div_cnt >= rate_divider) begin
            div_cnt <= 8'h00;
            sample_strobe_o <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            sample_strobe_o <= 1'b0;
        end
    end else begin
        sample_strobe_o <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// frame-sync capture and tagging

frame_sync_latch u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .frame_sync_pin_i(frame_sync_pin_i),
    .sample_strobe_i(sample_strobe_o),
    .latched_o(sync_latched),
    .captured_o(sync_captured)
);

// tag placement
// one-hot order: temp, gyro x, y, z, accel x, y, z; none when disabled
always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        sync_dest_o <= 7'h00;
        sync_bit_o <= 1'b0;
    end else begin
        if (sync_sel == `SYNC_SEL_OFF) begin
            sync_dest_o <= 7'h00;
            sync_bit_o <= 1'b0;
        end else begin
            sync_dest_o <= 7'h01 << (sync_sel - 3'h1);
            sync_bit_o <= sync_captured;
        end
    end
end

endmodule

// File: verif/gyro_cfg_asserts.sv
// checker for the gyro config block: bus answers, path rate, sync tag
// assumes it is bound to every instance of the config block
module gyro_cfg_asserts (
    input wire clock_i,
    input wire rst_n_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire frame_sync_pin_i,
    input wire queue_discard_on_full_o,
    input wire [1:0] rate_range_sel_o,
    input wire [2:0] rate_selftest_o,
    input wire [1:0] path_rate_o,
    input wire lowpass_active_o,
    input wire [2:0] lowpass_selector_o,
    input wire sample_strobe_o,
    input wire [6:0] sync_dest_o,
    input wire sync_bit_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////
    // both write beats meet on one edge, as our host offers them
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_write_answer: assert property (write_taken |=> s_axi_bvalid)
        else $error("write not answered next cycle");
    chk_read_answer: assert property (read_taken |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_write_refused: assert property
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write beat accepted while answer pending");
    chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    chk_bypass_rate: assert property (!lowpass_active_o |->
        path_rate_o == 2'h2 && lowpass_selector_o == 3'h0)
        else $error("bypassed filter not on fastest path");
    chk_wide_rate: assert property (lowpass_active_o &&
        lowpass_selector_o inside {3'h0, 3'h7} |-> path_rate_o == 2'h1)
        else $error("selector 0 or 7 not on middle path");
    chk_narrow_rate: assert property (lowpass_active_o &&
        !(lowpass_selector_o inside {3'h0, 3'h7}) |-> path_rate_o == 2'h0)
        else $error("selector 1 to 6 not on slow path");
    chk_strobe_single: assert property
        (sample_strobe_o |=> !sample_strobe_o)
        else $error("sample strobe longer than one cycle");
    chk_sync_onehot: assert property ($onehot0(sync_dest_o))
        else $error("sync tag aimed at more than one byte");
    chk_sync_off_quiet: assert property (sync_dest_o == 7'h00 |->
        !sync_bit_o)
        else $error("sync bit set while tagging is off");
endmodule

bind gyro_filter_sync_config gyro_cfg_asserts chk_u (.*);

// File: verif/axi_host.sv
// host model: one register write or read at a time over the bus
// assumes the slave answers; only the bench watchdog ends a wait
module axi_host (
    input wire clock_i,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    ////////////////////////////////////////////////////////////////////
    // readies sampled at the falling edge, so no race with the rising one;
    // released payloads show the inverse so stale values cannot pass
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic pa, pw, sa, sw, sb;
        begin
            @(posedge clock_i);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            sb = 1'b0;
            while (!sb) begin
                @(negedge clock_i);
                sa = pa && s_axi_awready;
                sw = pw && s_axi_wready;
                sb = s_axi_bvalid;
                r = s_axi_bresp;
                @(posedge clock_i);
                if (sa) begin
                    pa = 1'b0;
                    s_axi_awvalid <= 1'b0;
                    s_axi_awaddr <= ~a;
                end
                if (sw) begin
                    pw = 1'b0;
                    s_axi_wvalid <= 1'b0;
                    s_axi_wdata <= ~d;
                end
            end
            s_axi_bready <= 1'b0;
        end
    endtask
    // read: address held until taken, rready held until data arrive
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic pa, sa, sr;
        begin
            @(posedge clock_i);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            pa = 1'b1;
            sr = 1'b0;
            while (!sr) begin
                @(negedge clock_i);
                sa = pa && s_axi_arready;
                sr = s_axi_rvalid;
                d = s_axi_rdata;
                r = s_axi_rresp;
                @(posedge clock_i);
                if (sa) begin
                    pa = 1'b0;
                    s_axi_arvalid <= 1'b0;
                    s_axi_araddr <= ~a;
                end
            end
            s_axi_rready <= 1'b0;
        end
    endtask
endmodule

// File: verif/gyro_filter_sync_config_tb.sv
// bench for the gyro config block: registers, path rates, sync tagging
// assumes the host model and the checker are compiled alongside
`include "gyro_cfg_map.vh"
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
    $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    err_total++; end end
module gyro_filter_sync_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, rst_n_i, frame_sync_pin_i;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rate_range_sel_o, path_rate_o;
    logic [1:0] rsp, ep;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, queue_discard_on_full_o;
    logic lowpass_active_o, sample_strobe_o, sync_bit_o;
    logic [2:0] rate_selftest_o, lowpass_selector_o;
    logic [6:0] sync_dest_o;
    int err_total = 0;
    int checks = 0;
    int n;
    // short 1 kHz tick keeps the divider test fast
    gyro_filter_sync_config #(.INT_1K_CYCLES(40)) dut_u (.*);
    axi_host host_u (.*);
    // 20 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        host_u.read_reg(a, rd, rsp);
        `CHK("read data", e, rd)
        `CHK("read resp", `RESP_OKAY, rsp)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_u.write_reg(a, d, rsp);
    endtask
    task automatic wait_strobe;
        do @(negedge clock_i); while (sample_strobe_o !== 1'b1);
    endtask
    // first strobe after a path change may come early, so skip two
    task automatic period(output int c);
        wait_strobe;
        wait_strobe;
        c = 0;
        do begin
            @(negedge clock_i);
            c++;
        end while (sample_strobe_o !== 1'b1);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog well above the roughly 25000 cycles the tests need
    initial begin
        repeat (60000) @(posedge clock_i);
        err_total++;
        finish_test;
    end
    // main sequence
    initial begin
        rst_n_i = 1'b0;
        frame_sync_pin_i = 1'b0;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(negedge clock_i);
        `CHK("path after reset", `PATH_8K, path_rate_o)
        rd_chk(`GENERAL_CONFIG_ADDR, 32'h0);
        rd_chk(`GYRO_CONFIG_ADDR, 32'h0);
        $display("test reset done");
        wr(`GENERAL_CONFIG_ADDR, 32'hff);
        rd_chk(`GENERAL_CONFIG_ADDR, 32'h7f);
        `CHK("discard policy", 1'b1, queue_discard_on_full_o)
        wr(`GYRO_CONFIG_ADDR, 32'hff);
        rd_chk(`GYRO_CONFIG_ADDR, 32'hfb);
        `CHK("selftest", 3'h7, rate_selftest_o)
        wr(`GENERAL_CONFIG_ADDR, 32'h0);
        `CHK("overwrite policy", 1'b0, queue_discard_on_full_o)
        wr(8'h00, 32'h5a);
        `CHK("unmapped write", `RESP_SLVERR, rsp)
        host_u.read_reg(8'h00, rd, rsp);
        `CHK("unmapped read", `RESP_SLVERR, rsp)
        for (n = 0; n < 4; n++) begin
            wr(`GYRO_CONFIG_ADDR, 32'(n << 3));
            `CHK("range", n[1:0], rate_range_sel_o)
        end
        $display("test access done");
        for (n = 0; n < 32; n++) begin
            wr(`GENERAL_CONFIG_ADDR, 32'(n % 8));
            wr(`GYRO_CONFIG_ADDR, 32'(n / 8));
            ep = (n >= 8) ? `PATH_32K : `PATH_1K;
            if (n == 0 || n == 7)
                ep = `PATH_8K;
            `CHK("lowpass active", n < 8, lowpass_active_o)
            `CHK("selector", 3'((n < 8) ? n : 0), lowpass_selector_o)
            `CHK("path rate", ep, path_rate_o)
        end
        $display("test path done");
        wr(`RATE_DIVIDER_ADDR, 32'h2);
        wr(`GYRO_CONFIG_ADDR, 32'h0);
        wr(`GENERAL_CONFIG_ADDR, 32'h1);
        period(n);
        `CHK("divided period", 120, n)
        wr(`GENERAL_CONFIG_ADDR, 32'h0);
        period(n);
        `CHK("undivided period", `CYC_8K, n)
        $display("test divider done");
        wr(`GYRO_CONFIG_ADDR, 32'h1);
        for (n = 0; n < 8; n++) begin
            wr(`GENERAL_CONFIG_ADDR, 32'(n << 3));
            wait_strobe;
            @(posedge clock_i);
            frame_sync_pin_i <= 1'b1;
            @(posedge clock_i);
            frame_sync_pin_i <= 1'b0;
            // status: latched set, nothing captured yet, 32 kHz bypass path
            rd_chk(`STATUS_ADDR, 32'h12);
            wait_strobe;
            repeat (3) @(negedge clock_i);
            `CHK("sync bit", n > 0, sync_bit_o)
            `CHK("sync dest", 7'((1 << n) >> 1), sync_dest_o)
            wait_strobe;
            repeat (3) @(negedge clock_i);
            `CHK("sync bit back", 1'b0, sync_bit_o)
        end
        $display("test sync done");
        finish_test;
    end
endmodule
